/* File: inc/ctbm_pkg.sv */
// Package of constants and types for the channel trip bus matrix
//------------------------------------------------------------------------------
// Operation
// - Six internal lines for twelve channels
// - Each channel holds a 2N-bit internal word
// - Low internal bit k senses line k
// - Internal bit N+k propagates onto line k
// - Sense, propagate or both; source is over-current
// - Sensing channel trips when line asserted by others
// - Four external lines, 8-bit external word
// - External bit k senses mainframe line k
// - External bit 4+k drives mainframe line k
// - Mainframe line 0 exported as CPU trip
//------------------------------------------------------------------------------
`default_nettype none
package ctbm_pkg;
	// Geometry
	localparam int CTBM_NCH   = 12;
	localparam int CTBM_NINT  = CTBM_NCH / 2;
	localparam int CTBM_NEXT  = 4;
	localparam int CTBM_IW    = 2 * CTBM_NINT;
	localparam int CTBM_EW    = 2 * CTBM_NEXT;
	// Register map (word index, address port)
	localparam logic [7:0] CTBM_ADDR_INT0   = 8'h00;
	localparam logic [7:0] CTBM_ADDR_EXT0   = 8'h10;
	localparam logic [7:0] CTBM_ADDR_STATUS = 8'h20;
	localparam logic [7:0] CTBM_ADDR_MASK   = 8'h21;
	localparam logic [7:0] CTBM_ADDR_LINES  = 8'h22;
	// Reset values
	localparam logic [CTBM_IW-1:0]  CTBM_INT_RST  = '0;
	localparam logic [CTBM_EW-1:0]  CTBM_EXT_RST  = '0;
	localparam logic [CTBM_NCH-1:0] CTBM_MASK_RST = '0;
	// Trip lines travelling together
	typedef struct packed {
		logic [CTBM_NEXT-1:0] ext;
		logic [CTBM_NINT-1:0] int_l;
	} ctbm_lines_type;
	// Whole state of the block
	typedef struct packed {
		logic [CTBM_NCH-1:0][CTBM_IW-1:0] int_mask;
		logic [CTBM_NCH-1:0][CTBM_EW-1:0] ext_mask;
		logic [CTBM_NCH-1:0]              status;
		logic [CTBM_NCH-1:0]              irq_mask;
		logic [CTBM_NCH-1:0]              trip_out;
		ctbm_lines_type                   lines;
		logic [CTBM_NEXT-1:0]             ext_drive;
		logic                             cpu_trip;
		logic                             irq;
		logic [31:0]                      rdata;
		logic [CTBM_NEXT-1:0]             ext_s1;
		logic [CTBM_NEXT-1:0]             ext_s2;
		logic [CTBM_NCH-1:0]              oc_s1;
		logic [CTBM_NCH-1:0]              oc_s2;
	} ctbm_state_type;
endpackage : ctbm_pkg
`default_nettype wire

/* File: core/ctbm_matrix.sv */
// Trip propagation matrix with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module ctbm_matrix
	import ctbm_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Register port
	input  wire logic [7:0]            addr,
	input  wire logic [31:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output var  logic [31:0]           rdata,
	// Channel over-current and forced trip
	input  wire logic [CTBM_NCH-1:0]   oc_trip,
	output var  logic [CTBM_NCH-1:0]   trip_out,
	// Mainframe trip lines, open-drain style
	input  wire logic [CTBM_NEXT-1:0]  ext_line_in,
	output var  logic [CTBM_NEXT-1:0]  ext_line_oe,
	output var  logic                  cpu_trip,
	// Interrupt
	output var  logic                  irq
);
	ctbm_state_type st_ff;   // Registered state
	ctbm_state_type nxt_st;  // Next state

	// How the block behaves, in short:
	// - Every channel has an internal word (sense low half, propagate high half)
	//   and an external word (sense bits 3..0, drive bits 7..4).
	// - A line is the OR of every channel that propagates onto it and is in
	//   over-current; external lines also see what the mainframe pin shows.
	// - A channel trips on its own over-current or on any line it senses.
	// - Only a channel's own over-current feeds a line. A trip forced through a
	//   line never drives a line itself, so two channels that both sense and
	//   propagate cannot hold each other tripped once the cause is gone.
	// - The pin level of an external line already holds our own drive once the
	//   bus resolves it, so the pin path alone never sustains a trip either.
	// - Pins pass two flops first; a trip therefore shows three edges after the
	//   over-current input moves. That latency is the price of metastability
	//   safety and is far below any supply shutdown time.
	// - Status bits are sticky and cleared by writing ones; a new trip in the
	//   same cycle as the clear keeps its bit set, so no event is lost.
	// - Read data stand for one cycle after the read strobe, zero otherwise.

	// Decode of a channel-indexed word address, used for both maps
	function automatic logic chan_hit(input logic [7:0] a, input logic [7:0] base, input int ch);
		chan_hit = (a == base + 8'(ch));
	endfunction : chan_hit

	//--------------------------------------------------------------------------
	// Next-state logic
	//--------------------------------------------------------------------------
	// Trip propagation is computed from synchronised over-current only, so a
	// forced trip never feeds back onto a line and latches the bus.
	always_comb begin
		logic [CTBM_NINT-1:0] il;
		logic [CTBM_NEXT-1:0] ed;
		logic [CTBM_NCH-1:0]  tr;
		logic [CTBM_NCH-1:0]  ev;
		nxt_st = st_ff;
		il = '0;
		ed = '0;
		tr = '0;
		ev = '0;
		// Pin synchronisers
		nxt_st.ext_s1 = ext_line_in;
		nxt_st.ext_s2 = st_ff.ext_s1;
		nxt_st.oc_s1  = oc_trip;
		nxt_st.oc_s2  = st_ff.oc_s1;
		// Line OR of propagating channels
		for (int c = 0; c < CTBM_NCH; c++) begin
			for (int k = 0; k < CTBM_NINT; k++) begin
				if (st_ff.int_mask[c][CTBM_NINT+k] && st_ff.oc_s2[c]) begin
					il[k] = 1'b1;
				end
			end
			for (int k = 0; k < CTBM_NEXT; k++) begin
				if (st_ff.ext_mask[c][CTBM_NEXT+k] && st_ff.oc_s2[c]) begin
					ed[k] = 1'b1;
				end
			end
		end
		// Channel trips: own over-current or a sensed line
		for (int c = 0; c < CTBM_NCH; c++) begin
			tr[c] = st_ff.oc_s2[c];
			for (int k = 0; k < CTBM_NINT; k++) begin
				if (st_ff.int_mask[c][k] && il[k]) begin
					tr[c] = 1'b1;
				end
			end
			for (int k = 0; k < CTBM_NEXT; k++) begin
				// Sensed external line: driven by us or by the mainframe
				if (st_ff.ext_mask[c][k] && (ed[k] || st_ff.ext_s2[k])) begin
					tr[c] = 1'b1;
				end
			end
		end
		nxt_st.lines.int_l = il;
		nxt_st.lines.ext   = ed | st_ff.ext_s2;
		nxt_st.ext_drive   = ed;
		nxt_st.trip_out    = tr;
		nxt_st.cpu_trip    = ed[0] | st_ff.ext_s2[0];
		// New trip events (rising edge of a channel's trip)
		ev = tr & ~st_ff.trip_out;
		// Register writes
		if (wr) begin
			for (int c = 0; c < CTBM_NCH; c++) begin
				if (chan_hit(addr, CTBM_ADDR_INT0, c)) begin
					nxt_st.int_mask[c] = wdata[CTBM_IW-1:0];
				end
				if (chan_hit(addr, CTBM_ADDR_EXT0, c)) begin
					nxt_st.ext_mask[c] = wdata[CTBM_EW-1:0];
				end
			end
			if (addr == CTBM_ADDR_MASK) begin
				nxt_st.irq_mask = wdata[CTBM_NCH-1:0];
			end
		end
		// Write-one-to-clear status, new event wins over clear
		if (wr && addr == CTBM_ADDR_STATUS) begin
			nxt_st.status = (st_ff.status & ~wdata[CTBM_NCH-1:0]) | ev;
		end else begin
			nxt_st.status = st_ff.status | ev;
		end
		nxt_st.irq = |(nxt_st.status & nxt_st.irq_mask);
		// Read data, valid the cycle after the strobe
		nxt_st.rdata = '0;
		if (rd) begin
			for (int c = 0; c < CTBM_NCH; c++) begin
				if (chan_hit(addr, CTBM_ADDR_INT0, c)) begin
					nxt_st.rdata = 32'(st_ff.int_mask[c]);
				end
				if (chan_hit(addr, CTBM_ADDR_EXT0, c)) begin
					nxt_st.rdata = 32'(st_ff.ext_mask[c]);
				end
			end
			if (addr == CTBM_ADDR_STATUS) begin
				nxt_st.rdata = 32'(st_ff.status);
			end
			if (addr == CTBM_ADDR_MASK) begin
				nxt_st.rdata = 32'(st_ff.irq_mask);
			end
			if (addr == CTBM_ADDR_LINES) begin
				nxt_st.rdata = 32'(st_ff.lines);
			end
		end
	end

	//--------------------------------------------------------------------------
	// State register
	//--------------------------------------------------------------------------
	// Whole state in one register. Reset clears masks, status and the
	// synchronisers alike, so no line is driven until software has written a word,
	// and no line or trip shows until a pin has been seen high for two edges.
	// Reset only loads constants, so the flops stay plain reset flops.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flops
	// No logic sits between the state and a pin, so the board sees glitch-free
	// trip and drive levels even while a register write lands.
	assign rdata       = st_ff.rdata;
	assign trip_out    = st_ff.trip_out;
	assign ext_line_oe = st_ff.ext_drive;
	assign cpu_trip    = st_ff.cpu_trip;
	assign irq         = st_ff.irq;

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	// Own over-current always trips the channel
	property p_own_trip;
		@(posedge clk) disable iff (rst) (st_ff.oc_s2 != '0) |=> ((trip_out & $past(st_ff.oc_s2)) == $past(st_ff.oc_s2));
	endproperty
	a_own_trip: assert property (p_own_trip) else $error("own over-current did not trip channel");

	// Propagate bit N puts the channel on line 0
	property p_int_prop;
		@(posedge clk) disable iff (rst) (st_ff.int_mask[0][CTBM_NINT] && st_ff.oc_s2[0]) |=> st_ff.lines.int_l[0];
	endproperty
	a_int_prop: assert property (p_int_prop) else $error("internal line 0 not driven");

	// A sensing channel follows the line
	property p_int_sense;
		@(posedge clk) disable iff (rst)
			(st_ff.int_mask[1][0] && st_ff.int_mask[0][CTBM_NINT] && st_ff.oc_s2[0]) |=> trip_out[1];
	endproperty
	a_int_sense: assert property (p_int_sense) else $error("sensing channel missed line trip");

	// A channel that senses nothing has no other cause
	property p_no_sense;
		@(posedge clk) disable iff (rst)
			(st_ff.int_mask[1] == '0 && st_ff.ext_mask[1] == '0 && !st_ff.oc_s2[1]) |=> !trip_out[1];
	endproperty
	a_no_sense: assert property (p_no_sense) else $error("channel tripped without cause");

	// Drive bit 4+k asserts mainframe line k
	property p_ext_drive;
		@(posedge clk) disable iff (rst) (st_ff.ext_mask[2][CTBM_NEXT+1] && st_ff.oc_s2[2]) |=> ext_line_oe[1];
	endproperty
	a_ext_drive: assert property (p_ext_drive) else $error("external line 1 not driven");

	// A mainframe line seen at the pin trips its sensers
	property p_ext_sense;
		@(posedge clk) disable iff (rst) (st_ff.ext_mask[3][2] && st_ff.ext_s2[2]) |=> trip_out[3];
	endproperty
	a_ext_sense: assert property (p_ext_sense) else $error("external sense missed");

	// CPU trip follows line 0
	property p_cpu;
		@(posedge clk) disable iff (rst) ##1 (cpu_trip == ($past(st_ff.ext_s2[0]) | $past(st_ff.ext_drive[0])) ||
			cpu_trip == ($past(st_ff.ext_s2[0]) | ext_line_oe[0]));
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu trip disagrees with line 0");

	// No source, no line
	property p_or;
		@(posedge clk) disable iff (rst) (st_ff.oc_s2 == '0) |=> (st_ff.lines.int_l == '0 && ext_line_oe == '0);
	endproperty
	a_or: assert property (p_or) else $error("line asserted with no source");

	// Internal word is stored as written
	property p_wr_int;
		@(posedge clk) disable iff (rst) (wr && addr == CTBM_ADDR_INT0) |=> (st_ff.int_mask[0] == $past(wdata[CTBM_IW-1:0]));
	endproperty
	a_wr_int: assert property (p_wr_int) else $error("internal word not stored");

	// External word is stored as written
	property p_wr_ext;
		@(posedge clk) disable iff (rst) (wr && addr == CTBM_ADDR_EXT0) |=> (st_ff.ext_mask[0] == $past(wdata[CTBM_EW-1:0]));
	endproperty
	a_wr_ext: assert property (p_wr_ext) else $error("external word not stored");

	// The top internal line exists and is reached by the top propagate bit
	property p_six;
		@(posedge clk) disable iff (rst)
			(st_ff.int_mask[0][CTBM_IW-1] && st_ff.oc_s2[0]) |=> st_ff.lines.int_l[CTBM_NINT-1];
	endproperty
	a_six: assert property (p_six) else $error("top internal line not driven");
	c_int: cover property (@(posedge clk) disable iff (rst) st_ff.lines.int_l[0] && trip_out[5]);
	c_ext: cover property (@(posedge clk) disable iff (rst) ext_line_oe[0] && cpu_trip);
	c_irq: cover property (@(posedge clk) disable iff (rst) irq);
	c_all: cover property (@(posedge clk) disable iff (rst) trip_out[3] && trip_out[4] && trip_out[5]);

	//--------------------------------------------------------------------------
	// Register port and interrupt checks
	//--------------------------------------------------------------------------
	// Read data are zero unless a read was strobed one cycle earlier
	property p_rd_idle;
		@(posedge clk) disable iff (rst)
			!rd |=> (rdata == '0);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");

	// Internal word reads back in the cycle after the strobe
	property p_rd_int;
		@(posedge clk) disable iff (rst)
			(rd && addr == CTBM_ADDR_INT0) |=> (rdata == 32'($past(st_ff.int_mask[0])));
	endproperty
	a_rd_int: assert property (p_rd_int) else $error("internal word read back wrong");

	// External word reads back in the cycle after the strobe
	property p_rd_ext;
		@(posedge clk) disable iff (rst)
			(rd && addr == CTBM_ADDR_EXT0) |=> (rdata == 32'($past(st_ff.ext_mask[0])));
	endproperty
	a_rd_ext: assert property (p_rd_ext) else $error("external word read back wrong");

	// Mask register is stored as written
	property p_wr_mask;
		@(posedge clk) disable iff (rst)
			(wr && addr == CTBM_ADDR_MASK) |=> (st_ff.irq_mask == $past(wdata[CTBM_NCH-1:0]));
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("mask not stored");

	// A new trip sets its sticky status bit in the same cycle
	property p_stat_set;
		@(posedge clk) disable iff (rst)
			$rose(trip_out[0]) |-> st_ff.status[0];
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("trip event not recorded");

	// Clearing a status bit only leaves it set when a new trip arrives
	property p_clr;
		@(posedge clk) disable iff (rst)
			(wr && addr == CTBM_ADDR_STATUS && wdata[3]) |=> (!st_ff.status[3] || trip_out[3]);
	endproperty
	a_clr: assert property (p_clr) else $error("status bit not cleared");

	// Interrupt level matches unmasked status
	property p_irq_level;
		@(posedge clk) disable iff (rst)
			irq == (|(st_ff.status & st_ff.irq_mask));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

	//--------------------------------------------------------------------------
	// Further trip path checks
	//--------------------------------------------------------------------------
	// A mainframe line is only driven by own over-current
	property p_oe_src;
		@(posedge clk) disable iff (rst)
			(ext_line_oe != '0) |-> ($past(st_ff.oc_s2) != '0);
	endproperty
	a_oe_src: assert property (p_oe_src) else $error("line driven without over-current");

	// Our own drive trips a channel sensing that line at once
	property p_ext_own;
		@(posedge clk) disable iff (rst)
			(st_ff.ext_mask[2][0] && st_ff.ext_mask[1][CTBM_NEXT] && st_ff.oc_s2[1]) |=> trip_out[2];
	endproperty
	a_ext_own: assert property (p_ext_own) else $error("own external drive not sensed");

	// Line 0 seen at the pin reaches the CPU trip
	property p_cpu_pin;
		@(posedge clk) disable iff (rst)
			st_ff.ext_s2[0] |=> cpu_trip;
	endproperty
	a_cpu_pin: assert property (p_cpu_pin) else $error("pin line 0 not exported");

	// Line state holds what the mainframe shows
	property p_line_ext;
		@(posedge clk) disable iff (rst)
			st_ff.ext_s2[2] |=> st_ff.lines.ext[2];
	endproperty
	a_line_ext: assert property (p_line_ext) else $error("external line state lost");

	// A channel that only propagates is never tripped by the line
	property p_prop_only;
		@(posedge clk) disable iff (rst)
			(st_ff.int_mask[0][CTBM_NINT-1:0] == '0 && st_ff.ext_mask[0][CTBM_NEXT-1:0] == '0 && !st_ff.oc_s2[0])
			|=> !trip_out[0];
	endproperty
	a_prop_only: assert property (p_prop_only) else $error("propagate-only channel tripped");
endmodule : ctbm_matrix
`default_nettype wire

/* File: verification/ctbm_mainframe_model.sv */
// Mainframe trip bus model: wired OR of this board and other boards
`timescale 1ns/1ps
`default_nettype none
module ctbm_mainframe_model
	import ctbm_pkg::*;
(
	// Drives from this board and from other boards
	input  wire logic [CTBM_NEXT-1:0] board_oe,
	input  wire logic [CTBM_NEXT-1:0] other_drive,
	// Resolved line levels seen at the pins
	output var  logic [CTBM_NEXT-1:0] line_level
);
	//--------------------------------------------------------------------------
	// Line resolution
	//--------------------------------------------------------------------------
	// Any driver asserts the line; our own drive is seen on the pin as well
	always_comb begin
		line_level = board_oe | other_drive;
	end
endmodule : ctbm_mainframe_model
`default_nettype wire

/* File: verification/tb_channel_trip_bus_matrix.sv */
// Self-checking testbench for the trip matrix
`timescale 1ns/1ps
`default_nettype none
module tb_channel_trip_bus_matrix;
	import ctbm_pkg::*;
	//--------------------------------------------------------------------------
	// Stimulus and observed signals
	//--------------------------------------------------------------------------
	logic                 clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0]           addr = 8'h00;
	logic [31:0]          wdata = 32'h0, rdata, rv;
	logic [CTBM_NCH-1:0]  oc_trip = '0, trip_out;
	logic [CTBM_NEXT-1:0] other_drive = '0, ext_in, ext_oe;
	logic                 cpu_trip, irq;
	int                   n_mismatch = 0, n_compared = 0, cycles = 0;
	ctbm_matrix dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .oc_trip(oc_trip), .trip_out(trip_out), .ext_line_in(ext_in),
		.ext_line_oe(ext_oe), .cpu_trip(cpu_trip), .irq(irq));
	ctbm_mainframe_model mf (.board_oe(ext_oe), .other_drive(other_drive), .line_level(ext_in));
	// Free-running clock, 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end
	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end
	//--------------------------------------------------------------------------
	// Tasks
	//--------------------------------------------------------------------------
	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read strobe, data sampled in the following cycle only
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	// Let the two-flop sync and the registered outputs settle
	task automatic settle();
		repeat (8) @(posedge clk);
		#1;
	endtask : settle
	// Verdict and end of run
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	//--------------------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Reset values and an unmapped address
		rd_reg(CTBM_ADDR_INT0 + 8'h3, rv); check("int3 rst", rv, 32'h0);
		rd_reg(CTBM_ADDR_EXT0 + 8'hb, rv); check("ext11 rst", rv, 32'h0);
		rd_reg(8'h30, rv); check("unmapped", rv, 32'h0);
		// Full-width words, upper bits dropped
		wr_reg(CTBM_ADDR_INT0 + 8'hb, 32'hffffffff);
		rd_reg(CTBM_ADDR_INT0 + 8'hb, rv); check("int11 max", rv, 32'h00000fff);
		wr_reg(CTBM_ADDR_EXT0 + 8'h7, 32'hffffffff);
		rd_reg(CTBM_ADDR_EXT0 + 8'h7, rv); check("ext7 max", rv, 32'h000000ff);
		wr_reg(CTBM_ADDR_INT0 + 8'hb, 32'h0);
		wr_reg(CTBM_ADDR_EXT0 + 8'h7, 32'h0);
		// Internal bus: ch0 propagates, ch3/ch4 both, ch5 senses line 0
		wr_reg(CTBM_ADDR_INT0 + 8'h0, 32'h40);
		wr_reg(CTBM_ADDR_INT0 + 8'h3, 32'h41);
		wr_reg(CTBM_ADDR_INT0 + 8'h4, 32'h41);
		wr_reg(CTBM_ADDR_INT0 + 8'h5, 32'h01);
		wr_reg(CTBM_ADDR_MASK, 32'h008);
		oc_trip <= 12'h008;
		settle();
		check("trip ch3", {20'h0, trip_out}, 32'h038);
		rd_reg(CTBM_ADDR_LINES, rv); check("lines int", rv, 32'h001);
		rd_reg(CTBM_ADDR_STATUS, rv); check("status", rv, 32'h038);
		check("irq on", {31'h0, irq}, 32'h1);
		oc_trip <= 12'h001;
		settle();
		check("trip ch0", {20'h0, trip_out}, 32'h039);
		oc_trip <= 12'h000;
		settle();
		check("trip idle", {20'h0, trip_out}, 32'h0);
		wr_reg(CTBM_ADDR_MASK, 32'h000);
		#1 check("irq masked", {31'h0, irq}, 32'h0);
		wr_reg(CTBM_ADDR_MASK, 32'h008);
		wr_reg(CTBM_ADDR_STATUS, 32'h039);
		rd_reg(CTBM_ADDR_STATUS, rv); check("status clr", rv, 32'h0);
		check("irq off", {31'h0, irq}, 32'h0);
		// External bus: ch1 drives line 0, ch2 senses 0, ch6 senses 2
		wr_reg(CTBM_ADDR_EXT0 + 8'h1, 32'h10);
		wr_reg(CTBM_ADDR_EXT0 + 8'h2, 32'h01);
		wr_reg(CTBM_ADDR_EXT0 + 8'h6, 32'h04);
		oc_trip <= 12'h002;
		settle();
		check("ext oe", {28'h0, ext_oe}, 32'h1);
		check("cpu trip", {31'h0, cpu_trip}, 32'h1);
		check("trip ext0", {20'h0, trip_out}, 32'h006);
		oc_trip <= 12'h000;
		other_drive <= 4'h4;
		settle();
		check("trip ext2", {20'h0, trip_out}, 32'h040);
		check("oe idle", {27'h0, ext_oe, cpu_trip}, 32'h0);
		rd_reg(CTBM_ADDR_LINES, rv); check("lines ext", rv, 32'h100);
		report_and_stop();
	end
endmodule : tb_channel_trip_bus_matrix
`default_nettype wire
